/* verilog/tpw_timer_pwm.sv */
// Sixteen-bit timer with capture, compare and PWM channels and byte registers.
`timescale 1ns/10ps
`include "tpw_regs.svh"

module tpw_timer_pwm
	import tpw_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Register port.
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// System status and clock sources.
	input wire logic debug_halt_i,
	input wire logic fixed_tick_i,
	input wire logic ext_clk_i,
	// Channel pins.
	input wire logic [`TPW_NCH-1:0] ch_pin_i,
	output logic [`TPW_NCH-1:0] ch_out_o,
	output logic [`TPW_NCH-1:0] ch_oe_o,
	// Interrupt request.
	output logic irq_o
);

	tpw_state_t s_ff;
	tpw_state_t nxt_s;

	// Decodes the channel mode; the centre-aligned select overrides all.
	function automatic tpw_mode_t ch_mode(input logic cp, input logic [1:0] ms);
		tpw_mode_t m;
		m = TPW_MODE_EP;
		if (cp) begin
			m = TPW_MODE_CP;
		end else if (ms == 2'h0) begin
			m = TPW_MODE_IC;
		end else if (ms == 2'h1) begin
			m = TPW_MODE_OC;
		end
		return m;
	endfunction

	// Tells whether an address hits byte k of the three bytes of channel n.
	function automatic logic ch_hit(input logic [3:0] a, input int n,
		input logic [1:0] k);
		logic [3:0] base;
		base = `TPW_ADDR_CH_BASE + 4'(n) * `TPW_CH_STRIDE;
		return a == base + 4'(k);
	endfunction

	logic src;
	logic tick;
	logic ovf;
	logic to_top;
	logic [6:0] ps_max;
	logic [15:0] nc;
	logic [15:0] mod_eff;
	logic ndown;
	logic rise;
	logic fall;
	logic ev;
	logic act;
	tpw_mode_t m;

	// Whole next-state computation; flag events follow bus writes so events win, but a counter write beats the counter step.
	always_comb begin
		nxt_s = s_ff;
		src = 1'b0;
		tick = 1'b0;
		ovf = 1'b0;
		to_top = 1'b0;
		nc = s_ff.cnt;
		ndown = s_ff.down;
		rise = 1'b0;
		fall = 1'b0;
		ev = 1'b0;
		act = 1'b0;
		m = TPW_MODE_IC;
		nxt_s.rdata = 8'h00;
		ps_max = `TPW_PSC_FULL >> (`TPW_PS_TOP - s_ff.ps);
		mod_eff = (s_ff.mod == 16'h0000) ? `TPW_CNT_MAX : s_ff.mod;

		// Pin and external clock synchronisers.
		nxt_s.pin_s1 = ch_pin_i;
		nxt_s.pin_s2 = s_ff.pin_s1;
		nxt_s.pin_prev = s_ff.pin_s2;
		nxt_s.ext_s1 = ext_clk_i;
		nxt_s.ext_s2 = s_ff.ext_s1;
		nxt_s.ext_prev = s_ff.ext_s2;

		// Clock source and prescaler; the count freezes under debug halt.
		case (s_ff.clks)
			`TPW_CLKS_BUS: src = 1'b1;
			`TPW_CLKS_FIXED: src = fixed_tick_i;
			`TPW_CLKS_EXT: src = s_ff.ext_s2 & ~s_ff.ext_prev;
			default: src = 1'b0;
		endcase
		src = src & ~debug_halt_i;
		if (src) begin
			tick = s_ff.psc == ps_max;
			nxt_s.psc = tick ? 7'h00 : s_ff.psc + 7'h01;
		end

		// Counter stepping and overflow.
		if (tick) begin
			if (s_ff.center_align_select) begin
				if (!s_ff.down && s_ff.cnt == s_ff.mod) begin
					ndown = 1'b1;
					nc = s_ff.cnt - 16'h0001;
					ovf = 1'b1;
				end else if (s_ff.down && s_ff.cnt == 16'h0000) begin
					ndown = 1'b0;
					nc = 16'h0001;
				end else begin
					nc = s_ff.down ? s_ff.cnt - 16'h0001 : s_ff.cnt + 16'h0001;
				end
			end else begin
				ndown = 1'b0;
				if (s_ff.cnt == mod_eff) begin
					nc = 16'h0000;
					ovf = 1'b1;
				end else begin
					nc = s_ff.cnt + 16'h0001;
				end
			end
			to_top = !s_ff.down && nc == mod_eff;
		end
		nxt_s.cnt = nc;
		nxt_s.down = ndown;

		// Timer-wide register writes.
		if (wr_i) begin
			case (addr_i)
				`TPW_ADDR_SC: begin
					if (s_ff.tof_arm && !wdata_i[`TPW_SC_TOF]) begin
						nxt_s.overflow_flag = 1'b0;
						nxt_s.tof_arm = 1'b0;
					end
					nxt_s.overflow_irq_enable = wdata_i[`TPW_SC_OVERFLOW_IRQ_ENABLE];
					nxt_s.center_align_select = wdata_i[`TPW_SC_CENTER_ALIGN_SELECT];
					nxt_s.clks = wdata_i[`TPW_SC_CLKS_HI:`TPW_SC_CLKS_LO];
					nxt_s.ps = wdata_i[`TPW_SC_PS_HI:0];
					nxt_s.mod_wr = 2'h0;
					if (debug_halt_i) begin
						nxt_s.cnt_rd = 2'h0;
					end
				end
				`TPW_ADDR_CNTH, `TPW_ADDR_CNTL: begin
					nxt_s.cnt = 16'h0000;
					nxt_s.psc = 7'h00;
					nxt_s.down = 1'b0;
					if (debug_halt_i) begin
						nxt_s.cnt_rd = 2'h0;
					end
				end
				`TPW_ADDR_MODH: begin
					nxt_s.mod_buf[15:8] = wdata_i;
					nxt_s.mod_wr[1] = 1'b1;
				end
				`TPW_ADDR_MODL: begin
					nxt_s.mod_buf[7:0] = wdata_i;
					nxt_s.mod_wr[0] = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// The modulus loads at once when stopped, else at the period end.
		if (nxt_s.mod_wr == 2'h3 && (s_ff.clks == `TPW_CLKS_OFF || ovf)) begin
			nxt_s.mod = nxt_s.mod_buf;
			nxt_s.mod_wr = 2'h0;
		end

		// Timer-wide register reads; counter bytes read through a latch.
		if (rd_i) begin
			case (addr_i)
				`TPW_ADDR_SC: begin
					nxt_s.rdata = {s_ff.overflow_flag, s_ff.overflow_irq_enable, s_ff.center_align_select, s_ff.clks,
						s_ff.ps};
					if (s_ff.overflow_flag) begin
						nxt_s.tof_arm = 1'b1;
					end
				end
				`TPW_ADDR_CNTH, `TPW_ADDR_CNTL: begin
					if (debug_halt_i) begin
						nxt_s.rdata = addr_i[1] ? s_ff.cnt[7:0] : s_ff.cnt[15:8];
					end else begin
						if (s_ff.cnt_rd == 2'h0) begin
							nxt_s.cnt_lat = s_ff.cnt;
							nxt_s.rdata = addr_i[1] ? s_ff.cnt[7:0] : s_ff.cnt[15:8];
						end else begin
							nxt_s.rdata = addr_i[1] ? s_ff.cnt_lat[7:0]
								: s_ff.cnt_lat[15:8];
						end
						nxt_s.cnt_rd = s_ff.cnt_rd | {~addr_i[1], addr_i[1]};
						if (nxt_s.cnt_rd == 2'h3) begin
							nxt_s.cnt_rd = 2'h0;
						end
					end
				end
				`TPW_ADDR_MODH: nxt_s.rdata = s_ff.mod[15:8];
				`TPW_ADDR_MODL: nxt_s.rdata = s_ff.mod[7:0];
				default: begin
				end
			endcase
		end

		// Overflow flag; a new event beats a clear and restarts the sequence.
		if (ovf) begin
			nxt_s.overflow_flag = 1'b1;
			nxt_s.tof_arm = 1'b0;
		end

		// Per-channel registers, events and outputs.
		for (int i = 0; i < `TPW_NCH; i++) begin
			m = ch_mode(s_ff.center_align_select, s_ff.ms[i]);

			// Channel control write cancels a pending value write.
			if (wr_i && ch_hit(addr_i, i, 2'h0)) begin
				if (s_ff.chf_arm[i] && !wdata_i[`TPW_CSC_CHF]) begin
					nxt_s.chf[i] = 1'b0;
					nxt_s.chf_arm[i] = 1'b0;
				end
				nxt_s.chie[i] = wdata_i[`TPW_CSC_CHIE];
				nxt_s.ms[i] = wdata_i[`TPW_CSC_MS_HI:`TPW_CSC_MS_LO];
				nxt_s.els[i] = wdata_i[`TPW_CSC_ELS_HI:`TPW_CSC_ELS_LO];
				nxt_s.cv_wr[i] = 2'h0;
				if (debug_halt_i) begin
					nxt_s.cv_rd[i] = 2'h0;
				end
			end

			// Value bytes go to the write buffer unless the channel captures.
			if (wr_i && m != TPW_MODE_IC) begin
				if (ch_hit(addr_i, i, 2'h1)) begin
					nxt_s.cv_buf[i][15:8] = wdata_i;
					nxt_s.cv_wr[i][1] = 1'b1;
				end
				if (ch_hit(addr_i, i, 2'h2)) begin
					nxt_s.cv_buf[i][7:0] = wdata_i;
					nxt_s.cv_wr[i][0] = 1'b1;
				end
			end

			// Buffer transfer: stopped at once, compare on a step, PWM at top.
			if (s_ff.clks == `TPW_CLKS_OFF) begin
				if (nxt_s.cv_wr[i] == 2'h3) begin
					nxt_s.cv[i] = nxt_s.cv_buf[i];
					nxt_s.cv_wr[i] = 2'h0;
				end
			end else if (s_ff.cv_wr[i] == 2'h3 && nxt_s.cv_wr[i] == 2'h3) begin
				if ((m == TPW_MODE_OC && tick)
					|| (m != TPW_MODE_OC && m != TPW_MODE_IC && to_top)) begin
					nxt_s.cv[i] = s_ff.cv_buf[i];
					nxt_s.cv_wr[i] = 2'h0;
				end
			end

			// Channel reads; value bytes read through a coherency latch.
			if (rd_i && ch_hit(addr_i, i, 2'h0)) begin
				nxt_s.rdata = {s_ff.chf[i], s_ff.chie[i], s_ff.ms[i], s_ff.els[i],
					2'h0};
				if (s_ff.chf[i]) begin
					nxt_s.chf_arm[i] = 1'b1;
				end
			end
			if (rd_i && (ch_hit(addr_i, i, 2'h1) || ch_hit(addr_i, i, 2'h2))) begin
				if (debug_halt_i) begin
					nxt_s.rdata = ch_hit(addr_i, i, 2'h2) ? s_ff.cv[i][7:0]
						: s_ff.cv[i][15:8];
				end else begin
					if (s_ff.cv_rd[i] == 2'h0) begin
						nxt_s.cv_lat[i] = s_ff.cv[i];
						nxt_s.rdata = ch_hit(addr_i, i, 2'h2) ? s_ff.cv[i][7:0]
							: s_ff.cv[i][15:8];
					end else begin
						nxt_s.rdata = ch_hit(addr_i, i, 2'h2) ? s_ff.cv_lat[i][7:0]
							: s_ff.cv_lat[i][15:8];
					end
					nxt_s.cv_rd[i] = s_ff.cv_rd[i]
						| {ch_hit(addr_i, i, 2'h1), ch_hit(addr_i, i, 2'h2)};
					if (nxt_s.cv_rd[i] == 2'h3) begin
						nxt_s.cv_rd[i] = 2'h0;
					end
				end
			end

			// Mode-specific events and pin behaviour.
			rise = s_ff.pin_s2[i] & ~s_ff.pin_prev[i];
			fall = ~s_ff.pin_s2[i] & s_ff.pin_prev[i];
			ev = 1'b0;
			nxt_s.ch_oe[i] = m != TPW_MODE_IC && s_ff.els[i] != 2'h0;
			case (m)
				TPW_MODE_IC: begin
					ev = (s_ff.els[i][0] & rise) | (s_ff.els[i][1] & fall);
					if (ev) begin
						nxt_s.cv[i] = s_ff.cnt;
					end
				end
				TPW_MODE_OC: begin
					ev = tick && nc == s_ff.cv[i];
					if (ev) begin
						case (s_ff.els[i])
							2'h1: nxt_s.ch_out[i] = ~s_ff.ch_out[i];
							2'h2: nxt_s.ch_out[i] = 1'b0;
							2'h3: nxt_s.ch_out[i] = 1'b1;
							default: nxt_s.ch_out[i] = s_ff.ch_out[i];
						endcase
					end
				end
				TPW_MODE_EP: begin
					ev = tick && nc == s_ff.cv[i];
					// Only a counter step moves the output, so it holds when stopped.
					if (tick) begin
						act = nc < s_ff.cv[i];
						nxt_s.ch_out[i] = act ^ s_ff.els[i][0];
					end
				end
				TPW_MODE_CP: begin
					ev = tick && nc == s_ff.cv[i] && s_ff.cv[i] != 16'h0000;
					// Duty is sampled at period end so a period never mixes two values.
					if (ovf) begin
						nxt_s.duty[i] = s_ff.cv[i];
					end
					if (tick) begin
						if (s_ff.duty[i][15] || s_ff.duty[i] == 16'h0000) begin
							act = 1'b0;
						end else if (s_ff.duty[i] >= s_ff.mod) begin
							act = 1'b1;
						end else begin
							// The match count itself is active while counting down.
							act = ndown ? nc <= s_ff.duty[i] : nc < s_ff.duty[i];
						end
						nxt_s.ch_out[i] = act ^ s_ff.els[i][0];
					end
				end
				default: ev = 1'b0;
			endcase
			if (ev) begin
				nxt_s.chf[i] = 1'b1;
				nxt_s.chf_arm[i] = 1'b0;
			end
		end

		// Level interrupt from any enabled flag.
		nxt_s.irq = (nxt_s.overflow_flag & nxt_s.overflow_irq_enable) | (|(nxt_s.chf & nxt_s.chie));
	end

	// One register for all state; reset clears everything, clock stopped.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from flip-flops.
	assign rdata_o = s_ff.rdata;
	assign irq_o = s_ff.irq;
	assign ch_out_o = s_ff.ch_out;
	assign ch_oe_o = s_ff.ch_oe;

endmodule

/* verilog/tpw_regs.svh */
// Register offsets, field positions, reset values and counts of the timer block.
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// Number of timer channels.
`define TPW_NCH 2

// Byte offsets of the timer-wide registers.
`define TPW_ADDR_SC 4'h0
`define TPW_ADDR_CNTH 4'h1
`define TPW_ADDR_CNTL 4'h2
`define TPW_ADDR_MODH 4'h3
`define TPW_ADDR_MODL 4'h4

// Channel n status/control sits at CH_BASE + CH_STRIDE * n, value bytes after.
`define TPW_ADDR_CH_BASE 4'h5
`define TPW_CH_STRIDE 4'h3

// Timer status/control fields.
`define TPW_SC_TOF 7
`define TPW_SC_OVERFLOW_IRQ_ENABLE 6
`define TPW_SC_CENTER_ALIGN_SELECT 5
`define TPW_SC_CLKS_HI 4
`define TPW_SC_CLKS_LO 3
`define TPW_SC_PS_HI 2

// Channel status/control fields.
`define TPW_CSC_CHF 7
`define TPW_CSC_CHIE 6
`define TPW_CSC_MS_HI 5
`define TPW_CSC_MS_LO 4
`define TPW_CSC_ELS_HI 3
`define TPW_CSC_ELS_LO 2

// Clock source encodings.
`define TPW_CLKS_OFF 2'h0
`define TPW_CLKS_BUS 2'h1
`define TPW_CLKS_FIXED 2'h2
`define TPW_CLKS_EXT 2'h3

// Reset values and counter limits.
`define TPW_SC_RST 8'h00
`define TPW_MOD_RST 16'h0000
`define TPW_CNT_MAX 16'hffff
`define TPW_PSC_FULL 7'h7f
`define TPW_PS_TOP 3'h7

`endif

/* verilog/tpw_pkg.sv */
// Types shared by the timer block: channel modes and the state record.
package tpw_pkg;
`include "tpw_regs.svh"

	// Operating mode of one channel, one-hot.
	typedef enum logic [3:0] {
		TPW_MODE_IC = 4'h1,
		TPW_MODE_OC = 4'h2,
		TPW_MODE_EP = 4'h4,
		TPW_MODE_CP = 4'h8
	} tpw_mode_t;

	// Every flip-flop of the timer block.
	typedef struct packed {
		logic overflow_flag;
		logic tof_arm;
		logic overflow_irq_enable;
		logic center_align_select;
		logic [1:0] clks;
		logic [2:0] ps;
		logic [6:0] psc;
		logic [15:0] cnt;
		logic down;
		logic [15:0] mod;
		logic [15:0] mod_buf;
		logic [1:0] mod_wr;
		logic [15:0] cnt_lat;
		logic [1:0] cnt_rd;
		logic [`TPW_NCH-1:0] chf;
		logic [`TPW_NCH-1:0] chf_arm;
		logic [`TPW_NCH-1:0] chie;
		logic [`TPW_NCH-1:0][1:0] ms;
		logic [`TPW_NCH-1:0][1:0] els;
		logic [`TPW_NCH-1:0][15:0] cv;
		logic [`TPW_NCH-1:0][15:0] cv_buf;
		logic [`TPW_NCH-1:0][15:0] duty;
		logic [`TPW_NCH-1:0][15:0] cv_lat;
		logic [`TPW_NCH-1:0][1:0] cv_wr;
		logic [`TPW_NCH-1:0][1:0] cv_rd;
		logic [`TPW_NCH-1:0] pin_s1;
		logic [`TPW_NCH-1:0] pin_s2;
		logic [`TPW_NCH-1:0] pin_prev;
		logic ext_s1;
		logic ext_s2;
		logic ext_prev;
		logic [`TPW_NCH-1:0] ch_out;
		logic [`TPW_NCH-1:0] ch_oe;
		logic irq;
		logic [7:0] rdata;
	} tpw_state_t;
endpackage

/* dv/tpw_timer_pwm_chk.sv */
// Assertion checker bound to the ports of the timer block.
`timescale 1ns/10ps
module tpw_timer_pwm_chk (
	// Clock, reset and register port.
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Status, clock sources, pins and interrupt.
	input wire logic debug_halt_i,
	input wire logic fixed_tick_i,
	input wire logic ext_clk_i,
	input wire logic [1:0] ch_pin_i,
	input wire logic [1:0] ch_out_o,
	input wire logic [1:0] ch_oe_o,
	input wire logic irq_o
);
	logic [1:0] clks_ff;
	logic [2:0] ien_ff;
	logic [7:0] scw_ff;

	// Shadows of written fields, since the checker cannot see inside.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			clks_ff <= 2'h0;
			ien_ff <= 3'h0;
			scw_ff <= 8'h00;
		end else if (wr_i && addr_i == 4'h0) begin
			clks_ff <= wdata_i[4:3];
			ien_ff[0] <= wdata_i[6];
			scw_ff <= wdata_i;
		end else if (wr_i && addr_i == 4'h5) begin
			ien_ff[1] <= wdata_i[6];
		end else if (wr_i && addr_i == 4'h8) begin
			ien_ff[2] <= wdata_i[6];
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// A control write followed soon by a read of the same register.
	sequence s_sc_wr_rd;
		wr_i && addr_i == 4'h0 ##[1:2] rd_i && addr_i == 4'h0;
	endsequence

	// A counter write and a counter read, both while halted.
	sequence s_cnt_clr_rd;
		wr_i && addr_i == 4'h1 && debug_halt_i
		##[1:2] rd_i && addr_i inside {4'h1, 4'h2} && debug_halt_i;
	endsequence

	a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside an answer");
	a_unmapped_zero: assert property (rd_i && addr_i > 4'ha |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_sc_readback: assert property (s_sc_wr_rd |=> rdata_o[6:0] == scw_ff[6:0])
		else $error("control read does not match write");
	a_cnt_clear_read: assert property (
		s_cnt_clr_rd |=> rdata_o == 8'h00)
		else $error("counter not cleared or stale latch in halt");
	a_out_frozen: assert property (
		clks_ff == 2'h0 && !(wr_i && addr_i == 4'h0) |=> $stable(ch_out_o))
		else $error("channel output moved with clock off");
	a_irq_masked: assert property (
		ien_ff == 3'h0 && $past(ien_ff) == 3'h0 |-> !irq_o)
		else $error("interrupt raised with all enables clear");
	a_oe_off: assert property (
		wr_i && addr_i == 4'h5 && wdata_i[3:2] == 2'h0 |-> ##2 !ch_oe_o[0])
		else $error("output enable high with pin disconnected");
	a_oe_on: assert property (wr_i && addr_i == 4'h5 && wdata_i[5:4] != 2'h0
		&& wdata_i[3:2] != 2'h0 |-> ##2 ch_oe_o[0])
		else $error("output enable low in an output mode");
endmodule

bind tpw_timer_pwm tpw_timer_pwm_chk u_chk (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.debug_halt_i(debug_halt_i),
	.fixed_tick_i(fixed_tick_i),
	.ext_clk_i(ext_clk_i),
	.ch_pin_i(ch_pin_i),
	.ch_out_o(ch_out_o),
	.ch_oe_o(ch_oe_o),
	.irq_o(irq_o)
);

/* dv/tpw_pin_model.sv */
// Model of the far-side pins: capture inputs and an external clock.
`timescale 1ns/10ps
module tpw_pin_model (
	// Bench clock and requested pin levels.
	input wire logic clk_i,
	input wire logic [1:0] lvl_i,
	// Pins towards the timer.
	output wire logic [1:0] ch_pin_o,
	output logic ext_clk_o
);
	logic [1:0] div_ff;

	// Pins move off the bus clock edge, as real edges are unrelated to it.
	assign #13 ch_pin_o = lvl_i;

	// External clock at one sixth of the bus clock, skewed by 7 ns.
	initial div_ff = 2'h0;
	initial ext_clk_o = 1'b0;
	always @(posedge clk_i) begin
		if (div_ff == 2'h2) begin
			div_ff <= 2'h0;
			ext_clk_o <= #7 ~ext_clk_o;
		end else begin
			div_ff <= div_ff + 2'h1;
		end
	end
endmodule

/* dv/tpw_timer_pwm_tb.sv */
// Self-checking testbench for the timer block.
`timescale 1ns/10ps
module tpw_timer_pwm_tb;
	import tpw_pkg::*;
	logic clk_i, reset_n_i, wr_i, rd_i, debug_halt_i, fixed_tick_i, ext_clk_i;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o, rv;
	logic [1:0] lvl, ch_out_o, ch_oe_o, lv;
	wire logic [1:0] ch_pin_i;
	logic irq_o;
	int error_cnt, total_checks, n, t0, ones;
	int cyc = 0;
	int exp_src [3] = '{17, 68, 102};
	logic [7:0] sc_tab [3] = '{8'h08, 8'h08, 8'h28};
	logic [7:0] ch_tab [3] = '{8'h50, 8'h68, 8'h48};
	logic [7:0] cv_tab [3] = '{8'h10, 8'h0f, 8'h00};
	int duty_tab [3] = '{32, 30, 0};

	tpw_timer_pwm DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.debug_halt_i(debug_halt_i), .fixed_tick_i(fixed_tick_i),
		.ext_clk_i(ext_clk_i), .ch_pin_i(ch_pin_i), .ch_out_o(ch_out_o),
		.ch_oe_o(ch_oe_o), .irq_o(irq_o));
	tpw_pin_model u_pins (.clk_i(clk_i), .lvl_i(lvl), .ch_pin_o(ch_pin_i),
		.ext_clk_o(ext_clk_i));

	// Clock, cycle count and a fixed tick every fourth cycle.
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		fixed_tick_i <= (cyc % 4 == 0);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Accesses take two cycles, so a strobe is never set twice at once.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		#1 wr_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		#1 rd_i <= 1'b0;
		d = rdata_o;
		@(posedge clk_i);
		#1;
	endtask
	task automatic clr(input logic [3:0] a);
		logic [7:0] d;
		rd(a, d);
		wr(a, d & 8'h7f);
	endtask
	task automatic wait_irq(output int t);
		for (int k = 0; k < 70000 && irq_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		// A wait that runs out counts as a mismatch.
		chk(irq_o, 1'b1);
		t = cyc;
	endtask
	// Cycles between two interrupt rises, flag cleared in between.
	task automatic period(input logic [3:0] a, output int p);
		int t1;
		clr(a);
		wait_irq(t0);
		clr(a);
		wait_irq(t1);
		p = t1 - t0;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog sized above the long free-running overflow test.
	initial begin
		repeat (95000) @(posedge clk_i);
		error_cnt++;
		end_sim();
	end

	initial begin
		{error_cnt, total_checks} = '0;
		{reset_n_i, wr_i, rd_i, debug_halt_i} = '0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		lvl = 2'h0;
		repeat (5) @(posedge clk_i);
		#1 reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 chk({irq_o, ch_oe_o, ch_out_o}, 0);
		foreach (cv_tab[i]) begin
			rd(4'(i * 3), rv);
			chk(rv, 0);
			rd(4'(i * 3 + 4), rv);
			chk(rv, 0);
		end
		wr(4'hc, 8'hff);
		rd(4'hc, rv);
		chk(rv, 0);
		wr(0, 8'h48);
		wr(1, 8'h00);
		// The clearing write landed one edge before the task returned.
		t0 = cyc - 1;
		wait_irq(n);
		chk(16'(n - t0 >= 65536 && n - t0 <= 65537), 1);
		wr(0, 8'h40);
		wr(3, 8'h00);
		wr(4, 8'h10);
		for (int s = 1; s < 4; s++) begin
			wr(0, 8'h40 | 8'(s << 3));
			period(0, n);
			chk(16'(n), 16'(exp_src[s - 1]));
		end
		wait_irq(n);
		rd(0, rv);
		// Wait past one full period so a new overflow lands before the clear.
		repeat (110) @(posedge clk_i);
		#1 wr(0, rv & 8'h7f);
		rd(0, rv);
		chk(rv[7], 1);
		wait_irq(n);
		clr(0);
		rd(0, rv);
		chk({rv[7], irq_o}, 0);
		wr(0, 8'h68);
		period(0, n);
		chk(16'(n), 32);
		wr(0, 8'h08);
		wr(5, 8'h50);
		wr(6, 8'h00);
		wr(7, 8'h05);
		rd(6, rv);
		chk(rv, 0);
		rd(7, rv);
		chk(rv, 8'h05);
		foreach (sc_tab[i]) begin
			wr(0, sc_tab[i]);
			wr(5, ch_tab[i]);
			period(5, n);
			chk(16'(n == 17 || (i == 2 && (n == 10 || n == 22))), 1);
		end
		wr(0, 8'h08);
		wr(5, 8'h68);
		wr(0, 8'h00);
		lv = ch_out_o;
		repeat (20) @(posedge clk_i);
		#1 chk(ch_out_o, lv);
		wr(0, 8'h28);
		wr(5, 8'h08);
		foreach (cv_tab[i]) begin
			wr(6, 8'h00);
			wr(7, cv_tab[i]);
			repeat (70) @(posedge clk_i);
			ones = 0;
			repeat (32) begin
				@(posedge clk_i);
				#1 ones += ch_out_o[0];
			end
			chk(16'(ones), 16'(duty_tab[i]));
		end
		// Clock stopped, so an accepted value write would load at once.
		wr(0, 8'h00);
		wr(5, 8'h00);
		wr(6, 8'h12);
		wr(7, 8'h34);
		rd(6, rv);
		chk(rv, 0);
		rd(7, rv);
		chk(rv, 0);
		for (int e = 0; e < 4; e++) begin
			wr(5, 8'h40 | 8'(e << 2));
			clr(5);
			lvl <= 2'h1;
			repeat (8) @(posedge clk_i);
			#1 chk(irq_o, e[0]);
			clr(5);
			lvl <= 2'h0;
			repeat (8) @(posedge clk_i);
			#1 chk(irq_o, e[1]);
			clr(5);
		end
		debug_halt_i <= 1'b1;
		wr(0, 8'h00);
		wr(3, 8'haa);
		wr(0, 8'h00);
		wr(4, 8'h33);
		rd(3, rv);
		chk(rv, 0);
		rd(4, rv);
		chk(rv, 8'h10);
		wr(1, 8'h00);
		rd(2, rv);
		chk(rv, 0);
		debug_halt_i <= 1'b0;
		end_sim();
	end
endmodule
